// >>> shared/pwp_pkg.sv
// package of constants for the pixel width packer
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package pwp_pkg;
	localparam int PIX_W      = 24;
	localparam int CH_W       = 8;
	localparam int STREAM_W   = 32;
	localparam int FIFO_DEPTH = 8;
	localparam int CH0_LSB    = 0;
	localparam int CH1_LSB    = 8;
	localparam int CH2_LSB    = 16;
	localparam int CH3_LSB    = 24;
	localparam logic [1:0] BPP_8  = 2'h0;
	localparam logic [1:0] BPP_16 = 2'h1;
	localparam logic [1:0] BPP_24 = 2'h2;
	localparam logic [1:0] BPP_32 = 2'h3;
	localparam logic [1:0] BPP_RST = BPP_24;
	localparam logic       DIR_PACK   = 1'h0;
	localparam logic       DIR_UNPACK = 1'h1;
endpackage

// >>> logic/pwp_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/1ns
module pwp_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             CLOCK,
	input  wire logic             RST_N,
	// write side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_sof,
	// read side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_sof
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH:0] mem [DEPTH];
	logic [AW-1:0]  wr_ptr_r;
	logic [AW-1:0]  rd_ptr_r;
	logic [AW:0]    count_r;
	logic           push;
	logic           pop;

	assign in_ready  = (count_r != (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr_r][WIDTH-1:0];
	assign out_sof   = mem[rd_ptr_r][WIDTH];

	// storage is plain registers, no reset needed on data
	always_ff @(posedge CLOCK) begin
		if (push) begin
			mem[wr_ptr_r] <= {in_sof, in_data};
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end
endmodule // pwp_fifo

// >>> logic/pwp_top.sv
// pixel width packer / unpacker top
`timescale 1ns/1ns
module pwp_top (
	// clock and reset
	input  wire logic        CLOCK,
	input  wire logic        RST_N,
	// control from and status to the processor
	input  wire logic        DIRECTION,
	input  wire logic [1:0]  BPP_SEL,
	input  wire logic        RESAMPLE,
	output logic      [1:0]  BPP_ACTIVE,
	output logic             RESAMPLE_ACTIVE,
	output logic             DIR_ACTIVE,
	// input stream
	input  wire logic        S_VALID,
	output logic             S_READY,
	input  wire logic [31:0] S_DATA,
	input  wire logic        S_SOF,
	// output stream
	output logic             M_VALID,
	input  wire logic        M_READY,
	output logic      [31:0] M_DATA,
	output logic             M_SOF
);
	localparam int CW = pwp_pkg::CH_W;
	localparam int SW = pwp_pkg::STREAM_W;

	// ------------------------------------------------------------------------
	// configuration capture
	// ------------------------------------------------------------------------
	logic [1:0] bpp_r;
	logic       rs_r;
	logic       dir_r;
	logic       take;

	assign take = S_VALID && S_READY;

	// settings are latched only with a frame's first pixel, so a mid-frame
	// write from software waits for the next frame
	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			bpp_r <= pwp_pkg::BPP_RST;
			rs_r  <= 1'b0;
			dir_r <= pwp_pkg::DIR_PACK;
		end else if (take && S_SOF) begin
			bpp_r <= BPP_SEL;
			rs_r  <= RESAMPLE;
			dir_r <= DIRECTION;
		end
	end

	assign BPP_ACTIVE      = bpp_r;
	assign RESAMPLE_ACTIVE = rs_r;
	assign DIR_ACTIVE      = dir_r;

	// ------------------------------------------------------------------------
	// effective settings
	// ------------------------------------------------------------------------
	// a frame's first pixel already uses the settings it brings along
	logic [1:0] bpp_e;
	logic       rs_e;
	logic       dir_e;

	always_comb begin
		bpp_e = S_SOF ? BPP_SEL : bpp_r;
		rs_e  = S_SOF ? RESAMPLE : rs_r;
		dir_e = S_SOF ? DIRECTION : dir_r;
	end

	// ------------------------------------------------------------------------
	// pair phase
	// ------------------------------------------------------------------------
	// one bit changes per step along idle, odd, even, odd
	typedef enum logic [1:0] {
		PH_IDLE = 2'h0,
		PH_ODD  = 2'h1,
		PH_EVEN = 2'h3
	} pwp_phase_e;

	pwp_phase_e phase_r;
	pwp_phase_e phase_nxt;
	logic       odd_e;

	// restarted by each frame start so a lost pixel cannot skew the next frame
	always_comb begin
		phase_nxt = phase_r;
		case (phase_r)
			PH_IDLE: begin
				odd_e = 1'b0;
			end
			PH_ODD: begin
				odd_e = !S_SOF;
			end
			PH_EVEN: begin
				odd_e = 1'b0;
			end
			default: begin
				odd_e = 1'b0;
			end
		endcase
		if (take) begin
			if (odd_e) begin
				phase_nxt = PH_EVEN;
			end else begin
				phase_nxt = PH_ODD;
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			phase_r <= PH_IDLE;
		end else begin
			phase_r <= phase_nxt;
		end
	end

	// ------------------------------------------------------------------------
	// channel split
	// ------------------------------------------------------------------------
	localparam int            NCH   = pwp_pkg::PIX_W / CW;
	localparam logic [CW-1:0] NO_CH = '0;
	logic [CW-1:0] ch [NCH];

	// byte 3 of a packer input is never read, so only 24 bits enter
	for (genvar g = 0; g < NCH; g++) begin : g_chan
		assign ch[g] = S_DATA[pwp_pkg::CH0_LSB + g*CW +: CW];
	end

	// ------------------------------------------------------------------------
	// pack path
	// ------------------------------------------------------------------------
	logic [SW-1:0] pack_w;

	always_comb begin
		pack_w = '0;
		case (bpp_e)
			pwp_pkg::BPP_8: begin
				pack_w = {NO_CH, NO_CH, NO_CH, ch[0]};
			end
			pwp_pkg::BPP_16: begin
				if (!rs_e) begin
					pack_w = {NO_CH, NO_CH, ch[1], ch[0]};
				end else if (odd_e) begin
					pack_w = {NO_CH, NO_CH, ch[2], ch[0]};
				end else begin
					pack_w = {NO_CH, NO_CH, ch[1], ch[0]};
				end
			end
			pwp_pkg::BPP_24: begin
				pack_w = {NO_CH, ch[2], ch[1], ch[0]};
			end
			pwp_pkg::BPP_32: begin
				// channel four is the zero top byte
				pack_w = {NO_CH, ch[2], ch[1], ch[0]};
			end
			default: begin
				pack_w = '0;
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// unpack path
	// ------------------------------------------------------------------------
	logic [SW-1:0] unpack_w;

	always_comb begin
		unpack_w = '0;
		case (bpp_e)
			pwp_pkg::BPP_8: begin
				unpack_w = {NO_CH, NO_CH, NO_CH, ch[0]};
			end
			pwp_pkg::BPP_16: begin
				if (!rs_e) begin
					unpack_w = {NO_CH, NO_CH, ch[1], ch[0]};
				end else if (odd_e) begin
					unpack_w = {NO_CH, ch[1], NO_CH, ch[0]};
				end else begin
					unpack_w = {NO_CH, NO_CH, ch[1], ch[0]};
				end
			end
			pwp_pkg::BPP_24: begin
				unpack_w = {NO_CH, ch[2], ch[1], ch[0]};
			end
			pwp_pkg::BPP_32: begin
				// incoming fourth channel is dropped
				unpack_w = {NO_CH, ch[2], ch[1], ch[0]};
			end
			default: begin
				unpack_w = '0;
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// direction select
	// ------------------------------------------------------------------------
	logic [SW-1:0] conv;

	// both directions put the narrow word in the low bits of the 32-bit stream, except that
	// an odd resampled 16 bpp unpack places ch[1] in byte 2; the top byte of a packed 8/16/24 word reads as zero
	assign conv = (dir_e == pwp_pkg::DIR_UNPACK) ? unpack_w : pack_w;

	// ------------------------------------------------------------------------
	// output buffer
	// ------------------------------------------------------------------------
	// the fifo holds its head word until taken, giving stable output
	pwp_fifo #(
		.WIDTH (SW),
		.DEPTH (pwp_pkg::FIFO_DEPTH)
	) u_fifo (
		.CLOCK     (CLOCK),
		.RST_N     (RST_N),
		.in_valid  (S_VALID),
		.in_ready  (S_READY),
		.in_data   (conv),
		.in_sof    (S_SOF),
		.out_valid (M_VALID),
		.out_ready (M_READY),
		.out_data  (M_DATA),
		.out_sof   (M_SOF)
	);
endmodule // pwp_top

// >>> test/pwp_chk.sv
// assertions on the pixel width packer top ports
`timescale 1ns/1ns
module pwp_chk (
	input wire logic        CLOCK,
	input wire logic        RST_N,
	input wire logic        DIRECTION,
	input wire logic [1:0]  BPP_SEL,
	input wire logic        RESAMPLE,
	input wire logic [1:0]  BPP_ACTIVE,
	input wire logic        RESAMPLE_ACTIVE,
	input wire logic        DIR_ACTIVE,
	input wire logic        S_VALID,
	input wire logic        S_READY,
	input wire logic        S_SOF,
	input wire logic        M_VALID,
	input wire logic        M_READY,
	input wire logic [31:0] M_DATA,
	input wire logic        M_SOF
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	a_out_hold: assert property (M_VALID && !M_READY |=>
		M_VALID && $stable({M_DATA, M_SOF})) else $error("output moved");
	a_take_answer: assert property (S_VALID && S_READY && !M_VALID
		|=> M_VALID) else $error("late output");
	a_cfg_sample: assert property (S_VALID && S_READY && S_SOF |=>
		BPP_ACTIVE == $past(BPP_SEL) && DIR_ACTIVE == $past(DIRECTION)
		&& RESAMPLE_ACTIVE == $past(RESAMPLE)) else $error("cfg not taken");
	a_cfg_hold: assert property (!(S_VALID && S_READY && S_SOF) |=>
		$stable({BPP_ACTIVE, RESAMPLE_ACTIVE, DIR_ACTIVE}))
		else $error("cfg moved mid frame");
	a_byte_top: assert property (M_VALID && BPP_ACTIVE == pwp_pkg::BPP_8
		|-> M_DATA[31:8] == 24'h0) else $error("8 bpp upper bits");
	a_half_top: assert property (M_VALID && BPP_ACTIVE == pwp_pkg::BPP_16
		&& !RESAMPLE_ACTIVE |-> M_DATA[31:16] == 16'h0) else $error("16 bpp");
	a_pack_chroma: assert property (M_VALID && !DIR_ACTIVE
		&& BPP_ACTIVE == pwp_pkg::BPP_16 |-> M_DATA[31:16] == 16'h0)
		else $error("resample pack width");
	a_wide_top: assert property (M_VALID && BPP_ACTIVE[1]
		|-> M_DATA[31:24] == 8'h0) else $error("fourth channel");
	a_unpack_chroma: assert property (M_VALID && DIR_ACTIVE
		&& BPP_ACTIVE == pwp_pkg::BPP_16 && RESAMPLE_ACTIVE
		|-> M_DATA[31:24] == 8'h0
		&& (M_DATA[23:16] == 8'h0 || M_DATA[15:8] == 8'h0)
		&& (!M_SOF || M_DATA[23:16] == 8'h0))
		else $error("unpack chroma slot");
endmodule // pwp_chk

// >>> test/pwp_sink.sv
// downstream stage model with stalls
`timescale 1ns/1ns
module pwp_sink (
	input  wire logic CLOCK,
	input  wire logic RST_N,
	input  wire logic HOLD,
	output logic      M_READY
);
	logic [4:0] pat_r;
	always_ff @(posedge CLOCK or negedge RST_N)
		if (!RST_N) pat_r <= 5'h13;
		else pat_r <= {pat_r[3:0], pat_r[4] ^ pat_r[2]};
	// uneven stalls catch outputs that slip under backpressure
	assign M_READY = pat_r[0] && !HOLD;
endmodule // pwp_sink

// >>> test/pwp_top_test.sv
// self-checking bench for the pixel width packer
`timescale 1ns/1ns
module pwp_top_test;
	logic CLOCK = 0, RST_N, DIRECTION, RESAMPLE, S_VALID, S_SOF, hold;
	logic [1:0] BPP_SEL, BPP_ACTIVE;
	logic RESAMPLE_ACTIVE, DIR_ACTIVE, S_READY, M_VALID, M_READY, M_SOF;
	logic [31:0] S_DATA, M_DATA, r = 32'h25;
	logic [32:0] q[$];
	int miscompares = 0, tests_run = 0, n;
	logic [3:0] cfg_seen;
	assign cfg_seen = {BPP_ACTIVE, RESAMPLE_ACTIVE, DIR_ACTIVE};
	pwp_top i_pwp_top (
		.CLOCK           (CLOCK),
		.RST_N           (RST_N),
		.DIRECTION       (DIRECTION),
		.BPP_SEL         (BPP_SEL),
		.RESAMPLE        (RESAMPLE),
		.BPP_ACTIVE      (BPP_ACTIVE),
		.RESAMPLE_ACTIVE (RESAMPLE_ACTIVE),
		.DIR_ACTIVE      (DIR_ACTIVE),
		.S_VALID         (S_VALID),
		.S_READY         (S_READY),
		.S_DATA          (S_DATA),
		.S_SOF           (S_SOF),
		.M_VALID         (M_VALID),
		.M_READY         (M_READY),
		.M_DATA          (M_DATA),
		.M_SOF           (M_SOF)
	);
	pwp_sink i_pwp_sink (.CLOCK, .RST_N, .HOLD(hold), .M_READY);
	initial forever #20 CLOCK = ~CLOCK;
	function logic [31:0] lf(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function logic [31:0] pix_exp(logic dr, logic [1:0] b, logic rs,
		logic odd, logic [31:0] d);
		case (b)
			pwp_pkg::BPP_8: return {24'h0, d[7:0]};
			pwp_pkg::BPP_16: if (rs && odd) return dr ?
				{8'h0, d[15:8], 8'h0, d[7:0]} : {16'h0, d[23:16], d[7:0]};
			else return {16'h0, d[15:0]};
			default: return {8'h0, d[23:0]};
		endcase
	endfunction
	task give_verdict();
		if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task tally(string nm, logic [32:0] e, logic [32:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task chk_pixel(logic [32:0] e, logic [32:0] g);
		tally("pixel", e, g);
	endtask
	task chk_cfg(logic [3:0] e, logic [3:0] g);
		tally("config", {29'h0, e}, {29'h0, g});
	endtask
	task chk_flag(string nm, logic e, logic g);
		tally(nm, {32'h0, e}, {32'h0, g});
	endtask
	task send(logic sof, logic odd);
		r = lf(r);
		S_VALID <= 1;
		S_DATA <= r;
		S_SOF <= sof;
		n = 0;
		do begin @(negedge CLOCK); n++; end while (!S_READY && n < 300);
		if (n >= 300) chk_flag("take", 1'b0, 1'b1);
		if (n >= 300) give_verdict();
		q.push_back({sof, pix_exp(DIRECTION, BPP_SEL, RESAMPLE, odd, r)});
		@(posedge CLOCK);
	endtask
	task drain();
		n = 0;
		while (q.size() && n < 500) begin @(posedge CLOCK); n++; end
		if (n >= 500) chk_flag("drain", 1'b0, 1'b1);
		if (n >= 500) give_verdict();
	endtask
	always @(negedge CLOCK) if (M_VALID === 1'b1 && M_READY === 1'b1)
		chk_pixel(q.size() ? q.pop_front() : 'x, {M_SOF, M_DATA});
	initial begin
		{RST_N, S_VALID, S_SOF, hold, DIRECTION, RESAMPLE} = 0;
		BPP_SEL = 0;
		S_DATA = 0;
		repeat (6) @(posedge CLOCK);
		RST_N <= 1;
		@(negedge CLOCK);
		chk_cfg({pwp_pkg::BPP_RST, 1'b0, pwp_pkg::DIR_PACK}, cfg_seen);
		@(posedge CLOCK);
		for (int i = 0; i < 16; i++) begin
			DIRECTION <= i[3];
			BPP_SEL <= i[1:0];
			RESAMPLE <= i[2];
			for (int k = 0; k < 3; k++) send(k == 0, k[0]);
			S_VALID <= 0;
			drain();
			@(negedge CLOCK);
			chk_cfg({BPP_SEL, RESAMPLE, DIRECTION}, cfg_seen);
			@(posedge CLOCK);
		end
		hold <= 1;
		for (int k = 0; k < 8; k++) send(k == 0, k[0]);
		S_VALID <= 0;
		@(negedge CLOCK) chk_flag("full", 1'b0, S_READY);
		@(posedge CLOCK) hold <= 0;
		drain();
		give_verdict();
	end
endmodule // pwp_top_test
bind pwp_top pwp_chk i_pwp_chk (
	.CLOCK           (CLOCK),
	.RST_N           (RST_N),
	.DIRECTION       (DIRECTION),
	.BPP_SEL         (BPP_SEL),
	.RESAMPLE        (RESAMPLE),
	.BPP_ACTIVE      (BPP_ACTIVE),
	.RESAMPLE_ACTIVE (RESAMPLE_ACTIVE),
	.DIR_ACTIVE      (DIR_ACTIVE),
	.S_VALID         (S_VALID),
	.S_READY         (S_READY),
	.S_SOF           (S_SOF),
	.M_VALID         (M_VALID),
	.M_READY         (M_READY),
	.M_DATA          (M_DATA),
	.M_SOF           (M_SOF)
);
